// file: mec_pkg.sv
/*
 * mec_pkg: constants, register ids and helpers of the memory ECC
 * control and status block.
 * assumes: APB access, 22-bit byte address, one clock domain.
 */
package mec_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int ADDR_W   = 22;
    localparam int DATA_W   = 32;
    localparam int OFS_W    = 17;
    localparam int REGION_W = 5;
    localparam int NUM_CTRL = 8;
    localparam int CIDX_W   = 3;
    localparam int NUM_CH   = 16;
    localparam int CH_W     = 4;
    localparam int BEATS    = 4;
    localparam int BEAT_W   = 2;
    localparam int CNT_W    = 8;
    localparam int IVL_W    = 13;
    localparam int UNIT_W   = 8;
    localparam int TMR_W    = IVL_W + UNIT_W;
    localparam int WD_W     = 32;
    localparam int EN_BIT   = 0;

    // ------------------------------------------------------------
    // region tag and register offsets
    // ------------------------------------------------------------
    localparam logic [1:0]       REGION_TAG = 2'h1;
    localparam logic [OFS_W-1:0] OFS_CORR   = 17'h05800;
    localparam logic [OFS_W-1:0] OFS_SCRUB  = 17'h05804;
    localparam logic [OFS_W-1:0] OFS_IVL    = 17'h05810;
    localparam logic [OFS_W-1:0] OFS_CLR    = 17'h05818;
    localparam logic [OFS_W-1:0] OFS_S1P0   = 17'h05828;
    localparam logic [OFS_W-1:0] OFS_S2P0   = 17'h0582c;
    localparam logic [OFS_W-1:0] OFS_S1P1   = 17'h05834;
    localparam logic [OFS_W-1:0] OFS_S2P1   = 17'h05838;
    localparam logic [OFS_W-1:0] OFS_I1P0   = 17'h0584c;
    localparam logic [OFS_W-1:0] OFS_I2P0   = 17'h05850;
    localparam logic [OFS_W-1:0] OFS_I1P1   = 17'h05854;
    localparam logic [OFS_W-1:0] OFS_I2P1   = 17'h05858;

    // ------------------------------------------------------------
    // reset values and data constants
    // ------------------------------------------------------------
    localparam logic              CORR_EN_RST = 1'h1;
    localparam logic [IVL_W-1:0]  IVL_RST     = 13'h0002;
    // one interval unit is 256 clocks: the low byte of the period
    localparam logic [UNIT_W-1:0] UNIT_PAD    = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_MAX     = 8'hff;
    localparam logic [WD_W-1:0]   FLIP_ONE    = 32'h00000001;
    localparam logic [WD_W-1:0]   FLIP_TWO    = 32'h00000003;

    typedef enum logic [3:0] {
        R_NONE  = 4'h0, R_CORR = 4'h1, R_SCRUB = 4'h2, R_IVL  = 4'h3,
        R_CLR   = 4'h4, R_S1P0 = 4'h5, R_S2P0  = 4'h6, R_S1P1 = 4'h7,
        R_S2P1  = 4'h8, R_I1P0 = 4'h9, R_I2P0  = 4'ha, R_I1P1 = 4'hb,
        R_I2P1  = 4'hc
    } mec_reg_t;

    function automatic mec_reg_t mec_decode(input logic [OFS_W-1:0] o);
        case (o)
            OFS_CORR:  return R_CORR;
            OFS_SCRUB: return R_SCRUB;
            OFS_IVL:   return R_IVL;
            OFS_CLR:   return R_CLR;
            OFS_S1P0:  return R_S1P0;
            OFS_S2P0:  return R_S2P0;
            OFS_S1P1:  return R_S1P1;
            OFS_S2P1:  return R_S2P1;
            OFS_I1P0:  return R_I1P0;
            OFS_I2P0:  return R_I2P0;
            OFS_I1P1:  return R_I1P1;
            OFS_I2P1:  return R_I2P1;
            default:   return R_NONE;
        endcase
    endfunction

    // region 01xyz maps to controller {y,z,x}
    function automatic logic [CIDX_W-1:0] mec_ctrl_idx(
        input logic [REGION_W-1:0] r);
        return {r[1:0], r[2]};
    endfunction

    function automatic logic [BEATS-1:0] mec_beat_hot(
        input logic [BEAT_W-1:0] b);
        return 4'h1 << b;
    endfunction

    function automatic logic [CNT_W-1:0] mec_sat_inc(
        input logic [CNT_W-1:0] c);
        return (c == CNT_MAX) ? c : c + 8'h01;
    endfunction

    function automatic logic [TMR_W-1:0] mec_period(
        input logic [IVL_W-1:0] v);
        return {v, UNIT_PAD};
    endfunction

endpackage

// file: mec_chan.sv
/*
 * mec_chan: one pseudo channel: write-data error injection and the
 * saturating single and double error counters.
 * assumes: write beats and error pulses are synchronous to ref_clk.
 */
module mec_chan
    import mec_pkg::*;
(
    // clock and reset
    input  logic              ref_clk,
    input  logic              sys_rst,
    // controls from the register file
    input  logic [BEATS-1:0]  injSingle,
    input  logic [BEATS-1:0]  injDouble,
    input  logic              cntClear,
    // write data path
    input  logic              wrValid,
    input  logic [BEAT_W-1:0] wrBeat,
    input  logic [WD_W-1:0]   wrDataIn,
    output logic              wrValidOut,
    output logic [WD_W-1:0]   wrDataOut,
    // detected errors
    input  logic              errSingle,
    input  logic              errDouble,
    output logic [CNT_W-1:0]  singleCount,
    output logic [CNT_W-1:0]  doubleCount
);

    logic [BEATS-1:0] sPrev_q;
    logic [BEATS-1:0] dPrev_q;
    logic [BEATS-1:0] sArm_q;
    logic [BEATS-1:0] dArm_q;
    logic [BEATS-1:0] beatHot;
    logic [BEATS-1:0] hitD;
    logic [BEATS-1:0] hitS;
    logic [WD_W-1:0]  flipMask;

    // ------------------------------------------------------------
    // injection
    // ------------------------------------------------------------
    assign beatHot = wrValid ? mec_beat_hot(wrBeat) : '0;
    assign hitD    = dArm_q & beatHot;
    // a double hit wins the beat; the single stays armed
    assign hitS    = (|hitD) ? '0 : (sArm_q & beatHot);
    assign flipMask = (|hitD) ? FLIP_TWO :
                      (|hitS) ? FLIP_ONE : '0;

    // arm on a rising field bit only, so one setting injects once
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sPrev_q <= '0;
            dPrev_q <= '0;
            sArm_q  <= '0;
            dArm_q  <= '0;
        end
        else
        begin
            sPrev_q <= injSingle;
            dPrev_q <= injDouble;
            sArm_q  <= ((sArm_q & ~hitS) | (injSingle & ~sPrev_q))
                       & injSingle;
            dArm_q  <= ((dArm_q & ~hitD) | (injDouble & ~dPrev_q))
                       & injDouble;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wrValidOut <= 1'b0;
            wrDataOut  <= '0;
        end
        else
        begin
            wrValidOut <= wrValid;
            wrDataOut  <= wrDataIn ^ flipMask;
        end
    end

    // ------------------------------------------------------------
    // error counters
    // ------------------------------------------------------------
    // clear is a level: events during it are dropped
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || cntClear)
        begin
            singleCount <= '0;
            doubleCount <= '0;
        end
        else
        begin
            if (errSingle)
                singleCount <= mec_sat_inc(singleCount);
            if (errDouble)
                doubleCount <= mec_sat_inc(doubleCount);
        end
    end

    a_single_flip:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|hitS) |=> $countones(wrDataOut ^ $past(wrDataIn)) == 1)
    else $error("single inject did not flip one bit");

    a_double_flip:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|hitD) |=> $countones(wrDataOut ^ $past(wrDataIn)) == 2)
    else $error("double inject did not flip two bits");

    a_inject_once:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|hitS) |=> (sArm_q & $past(hitS)) == '0)
    else $error("inject stayed armed after use");

    a_count_step:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        errSingle && !cntClear && singleCount != CNT_MAX
        |=> singleCount == $past(singleCount) + 8'h01)
    else $error("single counter did not step");

    a_count_sat:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        doubleCount == CNT_MAX && !cntClear |=> doubleCount == CNT_MAX)
    else $error("double counter left saturation");

    a_clear_hold:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        cntClear |=> singleCount == '0 && doubleCount == '0)
    else $error("counters not held at zero");

endmodule // mec_chan

// file: mec_ecc_regs.sv
/*
 * mec_ecc_regs: ECC configuration and status registers of eight
 * memory controllers on one APB port, with scrub pacing and
 * per pseudo channel write error injection and error counters.
 * assumes: APB master on ref_clk, a SECDED datapath that reports
 * detected errors as one-cycle pulses and obeys corrEnable.
 */

// Function
// - one APB port per stack decodes its own 22-bit address space
// - top five address bits select one of eight controller regions
// - lower 17 address bits give the register offset in the region
// - each per-channel register exists for pseudo channel zero and one
// - correction enable bit resets to one and enables correct/detect
// - scrub runs only while scrub enable and correction enable are set
// - scrub reads correct single errors and only detect double errors
// - scrub reads spaced by interval times 256 clocks, reset value two
// - single inject bit corrupts one bit of the next write beat
// - double inject bit corrupts two bits of the next write beat
// - position of the set inject bit selects the beat of four
// - single error counter counts detected errors, saturating at 255
// - double error counter counts detected errors, saturating at max
// - counters reset to zero and hold until cleared
// - counters held at zero while clear bit is one
module mec_ecc_regs
    import mec_pkg::*;
(
    // clock and reset
    input  logic                          ref_clk,
    input  logic                          sys_rst,
    // apb register port
    input  logic [ADDR_W-1:0]             paddr,
    input  logic                          psel,
    input  logic                          penable,
    input  logic                          pwrite,
    input  logic [DATA_W-1:0]             pwdata,
    output logic                          pready,
    output logic [DATA_W-1:0]             prdata,
    output logic                          pslverr,
    // per controller controls
    output logic [NUM_CTRL-1:0]           corrEnable,
    output logic [NUM_CTRL-1:0]           scrubReq,
    // write data, channel index is controller*2 + pseudo channel
    input  logic [NUM_CH-1:0]             wrValid,
    input  logic [NUM_CH-1:0][BEAT_W-1:0] wrBeat,
    input  logic [NUM_CH-1:0][WD_W-1:0]   wrDataIn,
    output logic [NUM_CH-1:0]             wrValidOut,
    output logic [NUM_CH-1:0][WD_W-1:0]   wrDataOut,
    // error pulses from the decoder
    input  logic [NUM_CH-1:0]             errSingle,
    input  logic [NUM_CH-1:0]             errDouble
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [REGION_W-1:0] region;
    logic                regionOk;
    logic [CIDX_W-1:0]   cIdx;
    mec_reg_t            regId;
    logic                pcOne;
    logic [CH_W-1:0]     chIdx;
    logic                hit;
    logic                wrEn;
    logic [DATA_W-1:0]   rdMux;
    logic [DATA_W-1:0]   prdata_q;
    logic                pslverr_q;

    logic [NUM_CTRL-1:0] corrEn_q;
    logic [NUM_CTRL-1:0] scrubEn_q;
    logic [NUM_CTRL-1:0] clr_q;
    logic [IVL_W-1:0]    ivl_q [NUM_CTRL];
    logic [BEATS-1:0]    inj1_q [NUM_CH];
    logic [BEATS-1:0]    inj2_q [NUM_CH];
    logic [CNT_W-1:0]    sCnt [NUM_CH];
    logic [CNT_W-1:0]    dCnt [NUM_CH];

    logic [NUM_CTRL-1:0] scrubActive;
    logic [TMR_W-1:0]    tmr_q [NUM_CTRL];
    logic [NUM_CTRL-1:0] scrubReq_q;

    logic [TMR_W-1:0]    gap_q;
    logic                seen_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // the whole 22-bit space belongs to this port alone
    assign region   = paddr[ADDR_W-1 -: REGION_W];
    assign regionOk = (region[REGION_W-1 -: 2] == REGION_TAG);
    assign cIdx     = mec_ctrl_idx(region);
    assign regId    = mec_decode(paddr[OFS_W-1:0]);
    assign pcOne    = regId inside {R_S1P1, R_S2P1, R_I1P1, R_I2P1};
    assign chIdx    = {cIdx, pcOne};
    assign hit      = regionOk && (regId != R_NONE);
    assign wrEn     = psel && penable && pwrite && hit;

    // ------------------------------------------------------------
    // controller configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            corrEn_q  <= {NUM_CTRL{CORR_EN_RST}};
            scrubEn_q <= '0;
            clr_q     <= '0;
            for (int i = 0; i < NUM_CTRL; i++)
            begin
                ivl_q[i] <= IVL_RST;
            end
        end
        else if (wrEn)
        begin
            for (int i = 0; i < NUM_CTRL; i++)
            begin
                if (cIdx == CIDX_W'(i))
                begin
                    case (regId)
                        R_CORR:  corrEn_q[i]  <= pwdata[EN_BIT];
                        R_SCRUB: scrubEn_q[i] <= pwdata[EN_BIT];
                        R_IVL:   ivl_q[i]     <= pwdata[IVL_W-1:0];
                        R_CLR:   clr_q[i]     <= pwdata[EN_BIT];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // injection registers, one pair per pseudo channel
    // ------------------------------------------------------------
    // the field stays as written; rearming needs a clear then a set
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                inj1_q[i] <= '0;
                inj2_q[i] <= '0;
            end
        end
        else if (wrEn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (chIdx == CH_W'(i))
                begin
                    case (regId)
                        R_I1P0, R_I1P1:
                            inj1_q[i] <= pwdata[BEATS-1:0];
                        R_I2P0, R_I2P1:
                            inj2_q[i] <= pwdata[BEATS-1:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // counters are only looked at here, so a read changes nothing
    always_comb
    begin
        rdMux = '0;
        unique case (regId)
            R_CORR:
                rdMux[EN_BIT] = corrEn_q[cIdx];
            R_SCRUB:
                rdMux[EN_BIT] = scrubEn_q[cIdx];
            R_IVL:
                rdMux[IVL_W-1:0] = ivl_q[cIdx];
            R_CLR:
                rdMux[EN_BIT] = clr_q[cIdx];
            R_S1P0, R_S1P1:
                rdMux[CNT_W-1:0] = sCnt[chIdx];
            R_S2P0, R_S2P1:
                rdMux[CNT_W-1:0] = dCnt[chIdx];
            R_I1P0, R_I1P1:
                rdMux[BEATS-1:0] = inj1_q[chIdx];
            R_I2P0, R_I2P1:
                rdMux[BEATS-1:0] = inj2_q[chIdx];
            R_NONE:
                rdMux = '0;
        endcase
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // sampled in the setup phase so data sits in a flop for access
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_q  <= (pwrite || !hit) ? '0 : rdMux;
            pslverr_q <= !hit;
        end
    end

    // no wait states; writes to counters are accepted and dropped
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // scrub pacing
    // ------------------------------------------------------------
    // an interval of zero stops scrubbing rather than flooding reads
    always_comb
    begin
        for (int i = 0; i < NUM_CTRL; i++)
        begin
            scrubActive[i] = corrEn_q[i] && scrubEn_q[i]
                             && (ivl_q[i] != '0);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_CTRL; i++)
        begin
            if (sys_rst || !scrubActive[i])
            begin
                tmr_q[i]      <= '0;
                scrubReq_q[i] <= 1'b0;
            end
            else if (tmr_q[i] == mec_period(ivl_q[i]) - TMR_W'(1))
            begin
                tmr_q[i]      <= '0;
                scrubReq_q[i] <= 1'b1;
            end
            else
            begin
                tmr_q[i]      <= tmr_q[i] + TMR_W'(1);
                scrubReq_q[i] <= 1'b0;
            end
        end
    end

    // the decoder corrects on scrub reads only under corrEnable
    assign corrEnable = corrEn_q;
    assign scrubReq   = scrubReq_q;

    // ------------------------------------------------------------
    // pseudo channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan
        mec_chan u_chan (
            .ref_clk     (ref_clk),
            .sys_rst     (sys_rst),
            .injSingle   (inj1_q[g]),
            .injDouble   (inj2_q[g]),
            .cntClear    (clr_q[g/2]),
            .wrValid     (wrValid[g]),
            .wrBeat      (wrBeat[g]),
            .wrDataIn    (wrDataIn[g]),
            .wrValidOut  (wrValidOut[g]),
            .wrDataOut   (wrDataOut[g]),
            .errSingle   (errSingle[g]),
            .errDouble   (errDouble[g]),
            .singleCount (sCnt[g]),
            .doubleCount (dCnt[g])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // gap since the last scrub request of controller 0
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= scrubReq_q[0] ? TMR_W'(1) : gap_q + TMR_W'(1);
            seen_q <= (wrEn && cIdx == '0) || !scrubActive[0] ?
                      1'b0 : (seen_q || scrubReq_q[0]);
        end
    end

    a_corr_reset:
    assert property (@(posedge ref_clk)
        sys_rst |=> corrEnable == {NUM_CTRL{CORR_EN_RST}}
                    && scrubReq == '0)
    else $error("wrong state after reset");

    a_scrub_gate:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        scrubReq != '0
        |-> (scrubReq & $past(corrEn_q & scrubEn_q)) == scrubReq)
    else $error("scrub request while disabled");

    a_scrub_space:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        scrubReq[0] && seen_q |-> gap_q == mec_period(ivl_q[0]))
    else $error("scrub spacing wrong");

    a_bad_region:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        psel && !penable && !regionOk |=> pslverr)
    else $error("unmapped region not flagged");

    a_ctrl_select:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrEn && regId == R_CORR
        |=> corrEnable[$past(cIdx)] == $past(pwdata[EN_BIT]))
    else $error("write went to the wrong controller");

endmodule // mec_ecc_regs

// file: mec_apb_host.sv
/* mec_apb_host: APB master standing in for the host processor.
 * assumes: device inputs change at the falling edge of ref_clk. */
module mec_apb_host
    import mec_pkg::*;
(
    // clock and answer
    input  wire logic              ref_clk,
    input  wire logic              pready,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pslverr,
    // request
    output logic [ADDR_W-1:0]      paddr,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [DATA_W-1:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
        output logic e);
        @(negedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} = {2'b10, w, a, d};
        @(negedge ref_clk);
        penable = 1'b1;
        @(posedge ref_clk);
        // a hang is left to the bench watchdog, which counts it
        while (pready !== 1'b1)
            @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        @(negedge ref_clk);
        // released bus shows no stale address or data
        {psel, penable, paddr, pwdata} = {2'b00, ~a, ~d};
    endtask
endmodule // mec_apb_host

// file: mem_ecc_ctrl_status_tb_top.sv
/* mem_ecc_ctrl_status_tb_top: self-checking bench of mec_ecc_regs.
 * assumes: mec_apb_host drives the register port. */
module mem_ecc_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mec_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel, penable, pwrite;
    logic pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [NUM_CTRL-1:0] corrEnable, scrubReq;
    logic [NUM_CH-1:0] wrValid = '0, wrValidOut;
    logic [NUM_CH-1:0] errSingle = '0, errDouble = '0;
    logic [NUM_CH-1:0][BEAT_W-1:0] wrBeat = '0;
    logic [NUM_CH-1:0][WD_W-1:0] wrDataIn = '0, wrDataOut;
    int mismatches = 0, nCompared = 0;
    localparam logic [4:0] RGN[8] = '{5'h08, 5'h0c, 5'h09, 5'h0d,
                                      5'h0a, 5'h0e, 5'h0b, 5'h0f};
    always #50 ref_clk = ~ref_clk;
    mec_apb_host host (.ref_clk(ref_clk), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
    mec_ecc_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .corrEnable(corrEnable), .scrubReq(scrubReq),
        .wrValid(wrValid), .wrBeat(wrBeat), .wrDataIn(wrDataIn),
        .wrValidOut(wrValidOut), .wrDataOut(wrDataOut),
        .errSingle(errSingle), .errDouble(errDouble));
    function automatic logic [ADDR_W-1:0] ad(int c, logic [OFS_W-1:0] o);
        return {RGN[c], o};
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er);
    endtask
    task automatic rdc(string nm, logic [ADDR_W-1:0] a, logic [31:0] x);
        host.xfer(1'b0, a, '0, rd, er);
        check(nm, rd, x);
    endtask
    // one beat in, flipped bits expected on the delayed copy
    task automatic beat(int ch, logic [1:0] b, logic [31:0] flip);
        @(negedge ref_clk);
        {wrValid[ch], wrBeat[ch], wrDataIn[ch]} = {1'b1, b, 32'h5a5a0f0f};
        @(negedge ref_clk);
        {wrValid[ch], wrDataIn[ch]} = {1'b0, 32'ha5a5f0f0};
        check("wrDataOut", wrDataOut[ch], 32'h5a5a0f0f ^ flip);
        check("wrValidOut", {31'h0, wrValidOut[ch]}, 32'h1);
    endtask
    task automatic pulses(int ch, bit dbl, int n);
        @(negedge ref_clk);
        {errDouble[ch], errSingle[ch]} = {dbl, !dbl};
        repeat (n) @(negedge ref_clk);
        {errDouble[ch], errSingle[ch]} = 2'b00;
    endtask
    task automatic t_reset();
        check("corrEnable", {24'h0, corrEnable}, 32'hff);
        for (int c = 0; c < 8; c++)
        begin
            rdc("corr", ad(c, OFS_CORR), 32'h1);
            rdc("interval", ad(c, OFS_IVL), 32'h2);
        end
        rdc("count", ad(3, OFS_S2P1), 32'h0);
        check("slverr", {31'h0, er}, 32'h0);
        rdc("inject", ad(3, OFS_I1P0), 32'h0);
    endtask
    task automatic t_regions();
        for (int c = 0; c < 8; c++) wr(ad(c, OFS_IVL), c + 3);
        for (int c = 0; c < 8; c++)
            rdc("interval", ad(c, OFS_IVL), c + 3);
        rdc("bad region", {5'h10, OFS_IVL}, 32'h0);
        check("slverr", {31'h0, er}, 32'h1);
        host.xfer(1'b0, {RGN[0], 17'h15810}, '0, rd, er);
        check("slverr", {31'h0, er}, 32'h1);
        wr(ad(0, OFS_IVL), 32'hffffffff);
        rdc("interval", ad(0, OFS_IVL), 32'h1fff);
    endtask
    task automatic t_inject();
        wr(ad(0, OFS_I1P0), 32'h2);
        beat(0, 2'd0, 32'h0);
        beat(0, 2'd1, 32'h1);
        beat(0, 2'd1, 32'h0);
        wr(ad(0, OFS_I1P0), 32'h0);
        wr(ad(0, OFS_I1P0), 32'h2);
        beat(0, 2'd1, 32'h1);
        wr(ad(2, OFS_I2P1), 32'h8);
        beat(4, 2'd3, 32'h0);
        beat(5, 2'd3, 32'h3);
    endtask
    task automatic t_count();
        pulses(0, 1'b0, 3);
        rdc("single pc0", ad(0, OFS_S1P0), 32'h3);
        rdc("single pc1", ad(0, OFS_S1P1), 32'h0);
        wr(ad(0, OFS_S1P0), 32'h55);
        rdc("single pc0", ad(0, OFS_S1P0), 32'h3);
        rdc("single pc0", ad(0, OFS_S1P0), 32'h3);
        wr(ad(0, OFS_CLR), 32'h1);
        pulses(0, 1'b0, 2);
        rdc("cleared", ad(0, OFS_S1P0), 32'h0);
        wr(ad(0, OFS_CLR), 32'h0);
        pulses(0, 1'b0, 1);
        rdc("resumed", ad(0, OFS_S1P0), 32'h1);
        pulses(1, 1'b1, 260);
        rdc("double pc1", ad(0, OFS_S2P1), 32'hff);
        pulses(0, 1'b0, 300);
        rdc("single sat", ad(0, OFS_S1P0), 32'hff);
    endtask
    task automatic t_scrub();
        int n;
        wr(ad(0, OFS_IVL), 32'h1);
        wr(ad(0, OFS_SCRUB), 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(negedge ref_clk);
                n++;
            end
            while (scrubReq[0] !== 1'b1 && n < 600);
            if (k == 1) check("gap", n, 256);
        end
        check("others", {24'h0, scrubReq}, 32'h1);
        wr(ad(0, OFS_CORR), 32'h0);
        check("corrEnable", {24'h0, corrEnable}, 32'hfe);
        n = 0;
        repeat (600) @(negedge ref_clk) n += scrubReq[0];
        check("no scrub", n, 0);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: well beyond the roughly 1900 cycles the tests need
    initial
    begin
        #2000000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_regions();
        t_inject();
        t_count();
        t_scrub();
        report_and_stop();
    end
endmodule // mem_ecc_ctrl_status_tb_top
